// *** verification/ipc_checker.sv ***
// assertions on the isa carrier and the board end outputs
`timescale 1ns/1ps
module ipc_checker (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic [15:0] sa,
  input wire logic iow,
  input wire logic ior,
  input wire logic [15:0] wdata,
  input wire logic rvalid,
  input wire logic active_out,
  input wire logic [15:0] base_addr_out,
  input wire ipc_pkg::ipc_cfg_state_t cfg_state_out,
  input wire logic win_write_out,
  input wire logic [7:0] win_index_out,
  input wire logic [15:0] win_data_out
);
  wire key_wr = iow && sa == ipc_pkg::IPC_ADDR_PORT;
  wire cfg_wr = iow && sa == ipc_pkg::IPC_WDATA_PORT;
  wire [15:0] win_dp = {base_addr_out[15:5], ipc_pkg::IPC_WIN_DATA};

  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  property p_rd; rvalid |-> $past(ior); endproperty
  property p_key;
    cfg_state_out == ipc_pkg::IPC_SLEEP && $past(cfg_state_out) == ipc_pkg::IPC_WAIT4KEY
      |-> $past(key_wr);
  endproperty
  property p_sleep_src;
    cfg_state_out == ipc_pkg::IPC_SLEEP
      |-> $past(cfg_state_out) inside {ipc_pkg::IPC_WAIT4KEY, ipc_pkg::IPC_SLEEP};
  endproperty
  property p_wake;
    cfg_state_out == ipc_pkg::IPC_ISOLATE && $past(cfg_state_out) == ipc_pkg::IPC_SLEEP
      |-> $past(cfg_wr) && $past(wdata[7:0]) == ipc_pkg::IPC_WAKE_ALL;
  endproperty
  property p_csn;
    cfg_state_out == ipc_pkg::IPC_CONFIG && $past(cfg_state_out) == ipc_pkg::IPC_ISOLATE
      |-> $past(cfg_wr);
  endproperty
  property p_base;
    $changed(base_addr_out) |-> $past(cfg_wr) && $past(cfg_state_out) == ipc_pkg::IPC_CONFIG;
  endproperty
  property p_act;
    $rose(active_out) |-> cfg_state_out == ipc_pkg::IPC_WAIT4KEY && $past(cfg_wr);
  endproperty
  property p_win_addr;
    win_write_out |-> active_out && $past(iow) && $past(sa) == win_dp;
  endproperty
  property p_win_data;
    win_write_out |-> win_index_out < ipc_pkg::IPC_WIN_REGS && win_data_out == $past(wdata);
  endproperty
  property p_win_rd; ior && active_out && sa == win_dp |=> rvalid; endproperty

  a_rd: assert property (p_rd) else $error("answer without a read strobe");
  a_key: assert property (p_key) else $error("left key wait without key write");
  a_sleep_src: assert property (p_sleep_src) else $error("bad entry to sleep");
  a_wake: assert property (p_wake) else $error("isolation without wake");
  a_csn: assert property (p_csn) else $error("config without command");
  a_base: assert property (p_base) else $error("base moved outside config");
  a_act: assert property (p_act) else $error("activation misbehaved");
  a_win_addr: assert property (p_win_addr) else $error("window write off base");
  a_win_data: assert property (p_win_data) else $error("window write bad");
  a_win_rd: assert property (p_win_rd) else $error("window read unanswered");

  c_act: cover property ($rose(active_out));
  c_win: cover property (win_write_out);
  c_rd: cover property (rvalid);
endmodule

// *** verification/testbench.sv ***
// self-checking bench: host and board ends joined over the isa carrier
`timescale 1ns/1ps
module testbench;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic start_in = 1'b0;
  logic [15:0] base_addr_in = 16'h0000;
  logic [7:0] rd_port_in = 8'h00;
  logic [7:0] env_ofs_in = 8'h11;
  logic [15:0] env_data_in = 16'h5AA5;
  logic req_valid_in = 1'b0;
  logic req_write_in = 1'b0;
  logic [7:0] req_ofs_in = 8'h00;
  logic [15:0] req_wdata_in = 16'h0000;
  logic cfg_done_out, cfg_ok_out, req_ready_out, resp_valid_out, active_out, win_write_out;
  logic [15:0] resp_data_out, base_addr_out, win_data_out, base_b, rd;
  logic [7:0] win_index_out;
  logic cfg_busy_out;
  ipc_pkg::ipc_cfg_state_t cfg_state_out, state_b;
  int error_cnt = 0;
  int check_count = 0;
  ipc_isa_if bif ();
  ipc_isa_if bif_b ();

  always #20 mclk_in = ~mclk_in;
  initial begin
    bif_b.sa = 16'h0000;
    bif_b.iow = 1'b0;
    bif_b.ior = 1'b0;
    bif_b.wdata = 16'h0000;
  end

  ipc_host i_ipc_host (.mclk_in, .reset_in, .bus(bif.host), .start_in, .base_addr_in, .rd_port_in,
    .env_ofs_in, .env_data_in, .cfg_busy_out, .cfg_done_out, .cfg_ok_out, .req_valid_in,
    .req_write_in, .req_ofs_in, .req_wdata_in, .req_ready_out, .resp_valid_out, .resp_data_out);
  ipc_device i_ipc_device (.mclk_in, .reset_in, .bus(bif.dev), .active_out, .base_addr_out,
    .cfg_state_out, .win_write_out, .win_index_out, .win_data_out);
  // second board end, driven directly so that broken sequences can be sent
  ipc_device i_ipc_device_b (.mclk_in, .reset_in, .bus(bif_b.dev), .active_out(),
    .base_addr_out(base_b), .cfg_state_out(state_b), .win_write_out(), .win_index_out(),
    .win_data_out());
  ipc_checker i_ipc_checker (.mclk_in, .reset_in, .sa(bif.sa), .iow(bif.iow), .ior(bif.ior),
    .wdata(bif.wdata), .rvalid(bif.rvalid), .active_out, .base_addr_out, .cfg_state_out,
    .win_write_out, .win_index_out, .win_data_out);

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic stuck(input string what);
    error_cnt++;
    $display("BAD %s expected pulse seen timeout", what);
    wrap_up();
  endtask

  task automatic do_reset();
    @(posedge mclk_in);
    reset_in <= 1'b1;
    repeat (12) @(posedge mclk_in);
    reset_in <= 1'b0;
  endtask

  // released lines carry the inverse so that stale values are not decoded
  task automatic drv_b(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    bif_b.sa <= a;
    bif_b.wdata <= {8'h00, d};
    bif_b.iow <= 1'b1;
    @(posedge mclk_in);
    bif_b.iow <= 1'b0;
    bif_b.sa <= ~a;
    bif_b.wdata <= ~{8'h00, d};
  endtask

  task automatic send_key(input logic bad);
    logic [7:0] v;
    v = 8'h6A;
    for (int i = 0; i < 34; i++) begin
      if (i < 2) begin
        drv_b(ipc_pkg::IPC_ADDR_PORT, 8'h00);
      end else begin
        drv_b(ipc_pkg::IPC_ADDR_PORT, (bad && i == 33) ? ~v : v);
        v = {v[0] ^ v[1], v[7:1]};
      end
    end
    @(negedge mclk_in);
  endtask

  task automatic cfg_b(input logic [7:0] idx, input logic [7:0] d);
    drv_b(ipc_pkg::IPC_ADDR_PORT, idx);
    drv_b(ipc_pkg::IPC_WDATA_PORT, d);
    @(negedge mclk_in);
  endtask

  task automatic t_key();
    cfg_b(ipc_pkg::IPC_IDX_BASE_HI, 8'h12);
    check("base_b", 16'h0000, base_b);
    send_key(1'b1);
    check("state_b", 16'(ipc_pkg::IPC_WAIT4KEY), 16'(state_b));
    send_key(1'b0);
    check("state_b", 16'(ipc_pkg::IPC_SLEEP), 16'(state_b));
    cfg_b(ipc_pkg::IPC_IDX_BASE_HI, 8'h12);
    check("base_b", 16'h0000, base_b);
    cfg_b(ipc_pkg::IPC_IDX_WAKE, ipc_pkg::IPC_WAKE_ALL);
    check("state_b", 16'(ipc_pkg::IPC_ISOLATE), 16'(state_b));
    cfg_b(ipc_pkg::IPC_IDX_CTRL, 8'h02);
    check("state_b", 16'(ipc_pkg::IPC_WAIT4KEY), 16'(state_b));
    send_key(1'b0);
    cfg_b(ipc_pkg::IPC_IDX_CTRL, 8'h01);
    check("state_b", 16'(ipc_pkg::IPC_WAIT4KEY), 16'(state_b));
    $display("test key done");
  endtask

  task automatic configure(input logic [15:0] base, input logic [7:0] rdp);
    int i;
    @(posedge mclk_in);
    base_addr_in <= base;
    rd_port_in <= rdp;
    start_in <= 1'b1;
    @(posedge mclk_in);
    start_in <= 1'b0;
    @(negedge mclk_in);
    check("cfg_busy_out", 16'h0001, 16'(cfg_busy_out));
    for (i = 0; i < 400; i++) begin
      @(negedge mclk_in);
      if (cfg_done_out === 1'b1) break;
    end
    if (i == 400) stuck("cfg_done_out");
    check("cfg_ok_out", 16'h0001, 16'(cfg_ok_out));
    repeat (2) @(negedge mclk_in);
    check("base_addr_out", base, base_addr_out);
    check("active_out", 16'h0001, 16'(active_out));
    check("cfg_state_out", 16'(ipc_pkg::IPC_WAIT4KEY), 16'(cfg_state_out));
    check("win_index_out", {8'h00, env_ofs_in}, {8'h00, win_index_out});
    check("win_data_out", env_data_in, win_data_out);
    $display("test config done");
  endtask

  task automatic win(input logic wr, input logic [7:0] ofs, input logic [15:0] data);
    int i;
    for (i = 0; i < 50; i++) begin
      @(negedge mclk_in);
      if (req_ready_out === 1'b1) break;
    end
    if (i == 50) stuck("req_ready_out");
    @(posedge mclk_in);
    req_valid_in <= 1'b1;
    req_write_in <= wr;
    req_ofs_in <= ofs;
    req_wdata_in <= data;
    @(posedge mclk_in);
    req_valid_in <= 1'b0;
    for (i = 0; i < 10; i++) begin
      @(negedge mclk_in);
      if (resp_valid_out === 1'b1) break;
    end
    if (i == 10) stuck("resp_valid_out");
    rd = resp_data_out;
  endtask

  task automatic t_window();
    win(1'b1, 8'h05, 16'hA5C3);
    @(negedge mclk_in);
    check("win_index_out", 16'h0005, {8'h00, win_index_out});
    check("win_data_out", 16'hA5C3, win_data_out);
    win(1'b1, 8'hB3, 16'h3C5A);
    win(1'b0, 8'h05, 16'h0000);
    check("read 05", 16'hA5C3, rd);
    win(1'b0, 8'hB3, 16'h0000);
    check("read B3", 16'h3C5A, rd);
    win(1'b1, 8'hB4, 16'hFFFF);
    win(1'b0, 8'hB4, 16'h0000);
    check("read B4", 16'h0000, rd);
    win(1'b0, env_ofs_in, 16'h0000);
    check("read env", env_data_in, rd);
    $display("test window done");
  endtask

  task automatic t_reboot();
    do_reset();
    @(negedge mclk_in);
    check("active_out", 16'h0000, 16'(active_out));
    check("base_addr_out", 16'h0000, base_addr_out);
    configure(16'hFFE0, 8'hFF);
    win(1'b0, env_ofs_in, 16'h0000);
    check("read env", env_data_in, rd);
    $display("test reboot done");
  endtask

  initial begin
    do_reset();
    t_key();
    configure(16'h0340, 8'h80);
    t_window();
    t_reboot();
    wrap_up();
  end
endmodule

// *** verilog/ipc_device.sv ***
// board end: plug and play config state machine and windowed register file
// Notes on behaviour
// [RL1] address port decoded at 0x279
// [RL2] write data port decoded at 0xA79
// [RL3] read port relocatable, returns selected register
// [RL4] host picks read port with low bits 11
// [RL5] read port set by address shifted two
// [RL6] four states, power up in wait-for-key
// [RL7] only 34-write key leaves wait-for-key
// [RL8] config reset clears registers, back to wait
// [RL9] wake command moves sleep to isolation
// [RL10] command moves isolation to configuration
// [RL11] resources written only in configuration
// [RL12] full 16-bit base decode, two bytes
// [RL13] base bytes read back as written
// [RL14] activation enables base, returns to wait
// [RL15] base held only in volatile flops
// [RL16] board registers at fixed base offsets
// [RL17] window reaches 180 controller registers
// [RL18] window write: offset then data
// [RL19] window read: offset then read data
// [RL20] host initialises environment registers once
// [RL21] window offset held until rewritten
// [RL22] no board response before activation
`timescale 1ns/1ps
module ipc_device (
  input wire logic mclk_in,
  input wire logic reset_in,
  ipc_isa_if.dev bus,
  output logic active_out,
  output logic [15:0] base_addr_out,
  output ipc_pkg::ipc_cfg_state_t cfg_state_out,
  output logic win_write_out,
  output logic [7:0] win_index_out,
  output logic [15:0] win_data_out
);
  ipc_pkg::ipc_cfg_state_t state;
  logic [7:0] cfg_index;
  logic [7:0] rd_port;
  logic [7:0] base_hi;
  logic [7:0] base_lo;
  logic [7:0] csn;
  logic active;
  logic [5:0] key_cnt;
  logic [7:0] key_lfsr;
  logic [7:0] win_ofs;
  logic [15:0] win_mem [0:179];
  logic [15:0] rdata;
  logic rvalid;
  logic [7:0] key_expect;
  logic key_match;
  logic key_done;
  logic addr_wr;
  logic data_wr;
  logic cfg_wr;
  logic ctrl_reset;
  logic ctrl_wait;
  logic act_wr;
  logic rdp_hit;
  logic board_hit;
  logic [4:0] board_sel;
  logic win_wr;
  logic win_in_range;
  logic [7:0] cfg_rd_mux;
  logic [15:0] base;

  assign base = {base_hi, base_lo};
  assign addr_wr = bus.iow && (bus.sa == ipc_pkg::IPC_ADDR_PORT); // [RL1]
  // data port ignored until the key has been seen
  assign data_wr = bus.iow && (bus.sa == ipc_pkg::IPC_WDATA_PORT)
                   && (state != ipc_pkg::IPC_WAIT4KEY); // [RL2] [RL22]
  assign cfg_wr = data_wr && (state == ipc_pkg::IPC_CONFIG); // [RL11]
  assign ctrl_reset = data_wr && (cfg_index == ipc_pkg::IPC_IDX_CTRL)
                      && bus.wdata[ipc_pkg::IPC_CTRL_RESET_BIT];
  assign ctrl_wait = data_wr && (cfg_index == ipc_pkg::IPC_IDX_CTRL)
                     && bus.wdata[ipc_pkg::IPC_CTRL_WAITKEY_BIT];
  assign act_wr = cfg_wr && (cfg_index == ipc_pkg::IPC_IDX_ACT);

  // key: two zero writes reset the sequence, then 32 lfsr bytes
  assign key_expect = (key_cnt < ipc_pkg::IPC_KEY_LEAD) ? ipc_pkg::IPC_KEY_ZERO : key_lfsr;
  assign key_match = addr_wr && (state == ipc_pkg::IPC_WAIT4KEY)
                     && (bus.wdata[7:0] == key_expect);
  assign key_done = key_match && (key_cnt == ipc_pkg::IPC_KEY_LEN - 6'h01); // [RL7]

  // read port sits at {rd_port, 11}; unassigned while below the legal range
  assign rdp_hit = bus.ior && (rd_port >= ipc_pkg::IPC_RDP_MIN)
                   && ((state == ipc_pkg::IPC_ISOLATE) || (state == ipc_pkg::IPC_CONFIG))
                   && (bus.sa == {ipc_pkg::IPC_RDP_TOP, rd_port, ipc_pkg::IPC_RDP_LOW}); // [RL3] [RL5]

  // upper eleven address bits compared, low five bits select the register
  assign board_hit = active
                     && (bus.sa[15:ipc_pkg::IPC_SPAN_BITS] == base[15:ipc_pkg::IPC_SPAN_BITS]); // [RL12] [RL16] [RL22]
  assign board_sel = bus.sa[4:0];
  assign win_in_range = win_ofs < ipc_pkg::IPC_WIN_REGS; // [RL17]
  assign win_wr = bus.iow && board_hit && (board_sel == ipc_pkg::IPC_WIN_DATA) && win_in_range;

  always_comb begin
    unique case (cfg_index)
      ipc_pkg::IPC_IDX_RDPORT: cfg_rd_mux = rd_port;
      ipc_pkg::IPC_IDX_CSN: cfg_rd_mux = csn;
      ipc_pkg::IPC_IDX_ACT: cfg_rd_mux = {7'h00, active};
      ipc_pkg::IPC_IDX_BASE_HI: cfg_rd_mux = base_hi; // [RL13]
      ipc_pkg::IPC_IDX_BASE_LO: cfg_rd_mux = base_lo; // [RL13]
      default: cfg_rd_mux = 8'h00;
    endcase
  end

  // index register follows every address port write
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      cfg_index <= 8'h00;
    end else if (addr_wr) begin
      cfg_index <= bus.wdata[7:0]; // [RL1]
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      key_cnt <= 6'h00;
      key_lfsr <= ipc_pkg::IPC_KEY_SEED;
    end else if (addr_wr && (state == ipc_pkg::IPC_WAIT4KEY)) begin
      if (key_done) begin
        key_cnt <= 6'h00;
      end else if (key_match) begin
        key_cnt <= key_cnt + 6'h01; // [RL7]
        if (key_cnt >= ipc_pkg::IPC_KEY_LEAD) begin
          key_lfsr <= ipc_pkg::ipc_lfsr_next(key_lfsr);
        end
      end else begin
        // a stray zero may still open a fresh key
        key_cnt <= (bus.wdata[7:0] == ipc_pkg::IPC_KEY_ZERO) ? 6'h01 : 6'h00; // [RL7]
        key_lfsr <= ipc_pkg::IPC_KEY_SEED;
      end
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      state <= ipc_pkg::IPC_WAIT4KEY; // [RL6]
    end else if (ctrl_reset || ctrl_wait) begin
      state <= ipc_pkg::IPC_WAIT4KEY; // [RL8]
    end else begin
      unique case (state)
        ipc_pkg::IPC_WAIT4KEY: begin
          if (key_done) begin
            state <= ipc_pkg::IPC_SLEEP; // [RL7]
          end
        end
        ipc_pkg::IPC_SLEEP: begin
          if (data_wr && (cfg_index == ipc_pkg::IPC_IDX_WAKE)
              && (bus.wdata[7:0] == ipc_pkg::IPC_WAKE_ALL)) begin
            state <= ipc_pkg::IPC_ISOLATE; // [RL9]
          end
        end
        ipc_pkg::IPC_ISOLATE: begin
          if (data_wr && (cfg_index == ipc_pkg::IPC_IDX_CSN)) begin
            state <= ipc_pkg::IPC_CONFIG; // [RL10]
          end
        end
        ipc_pkg::IPC_CONFIG: begin
          if (act_wr && bus.wdata[ipc_pkg::IPC_ACT_BIT]) begin
            state <= ipc_pkg::IPC_WAIT4KEY; // [RL14]
          end
        end
      endcase
    end
  end

  // plain flops, cleared by reset: nothing survives a restart
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      rd_port <= 8'h00; // [RL15]
      base_hi <= 8'h00;
      base_lo <= 8'h00;
      csn <= 8'h00;
      active <= 1'b0;
    end else if (ctrl_reset) begin
      rd_port <= 8'h00; // [RL8]
      base_hi <= 8'h00;
      base_lo <= 8'h00;
      csn <= 8'h00;
      active <= 1'b0;
    end else begin
      if (data_wr && (state == ipc_pkg::IPC_ISOLATE)
          && (cfg_index == ipc_pkg::IPC_IDX_CSN)) begin
        csn <= bus.wdata[7:0];
      end
      if (cfg_wr && (cfg_index == ipc_pkg::IPC_IDX_RDPORT)) begin
        rd_port <= bus.wdata[7:0]; // [RL5] [RL11]
      end
      if (cfg_wr && (cfg_index == ipc_pkg::IPC_IDX_BASE_HI)) begin
        base_hi <= bus.wdata[7:0]; // [RL12]
      end
      if (cfg_wr && (cfg_index == ipc_pkg::IPC_IDX_BASE_LO)) begin
        base_lo <= bus.wdata[7:0]; // [RL12]
      end
      if (act_wr) begin
        active <= bus.wdata[ipc_pkg::IPC_ACT_BIT]; // [RL14]
      end
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      win_ofs <= 8'h00;
    end else if (bus.iow && board_hit && (board_sel == ipc_pkg::IPC_WIN_OFS)) begin
      win_ofs <= bus.wdata[7:0]; // [RL18] [RL19] [RL21]
    end
  end

  // array has no reset, like the controller it stands in for
  always_ff @(posedge mclk_in) begin
    if (win_wr) begin
      win_mem[win_ofs] <= bus.wdata; // [RL18]
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      win_write_out <= 1'b0;
      win_index_out <= 8'h00;
      win_data_out <= 16'h0000;
    end else begin
      win_write_out <= win_wr;
      if (win_wr) begin
        win_index_out <= win_ofs;
        win_data_out <= bus.wdata;
      end
    end
  end

  // one read answer, one cycle after the strobe; unmapped reads get none
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      rdata <= 16'h0000;
      rvalid <= 1'b0;
    end else begin
      rvalid <= 1'b0;
      if (rdp_hit) begin
        rdata <= {8'h00, cfg_rd_mux}; // [RL3]
        rvalid <= 1'b1;
      end else if (bus.ior && board_hit && (board_sel == ipc_pkg::IPC_WIN_DATA)) begin
        rdata <= win_in_range ? win_mem[win_ofs] : 16'h0000; // [RL19]
        rvalid <= 1'b1;
      end else if (bus.ior && board_hit && (board_sel == ipc_pkg::IPC_WIN_OFS)) begin
        rdata <= {8'h00, win_ofs};
        rvalid <= 1'b1;
      end
    end
  end

  assign bus.rdata = rdata;
  assign bus.rvalid = rvalid;
  assign active_out = active;
  assign base_addr_out = base;
  assign cfg_state_out = state;
endmodule

// *** verilog/ipc_host.sv ***
// host end: runs the configuration sequence, then windowed accesses
`timescale 1ns/1ps
module ipc_host (
  input wire logic mclk_in,
  input wire logic reset_in,
  ipc_isa_if.host bus,
  input wire logic start_in,
  input wire logic [15:0] base_addr_in,
  input wire logic [7:0] rd_port_in,
  input wire logic [7:0] env_ofs_in,
  input wire logic [15:0] env_data_in,
  output logic cfg_busy_out,
  output logic cfg_done_out,
  output logic cfg_ok_out,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [7:0] req_ofs_in,
  input wire logic [15:0] req_wdata_in,
  output logic req_ready_out,
  output logic resp_valid_out,
  output logic [15:0] resp_data_out
);
  typedef enum {
    IPC_H_IDLE,
    IPC_H_KEY,
    IPC_H_STEP,
    IPC_H_RD_WAIT,
    IPC_H_USR_DATA,
    IPC_H_USR_WAIT
  } ipc_host_state_t;

  ipc_host_state_t hstate;
  logic [15:0] base;
  logic [7:0] rd_port;
  logic [7:0] env_ofs;
  logic [15:0] env_data;
  logic [5:0] key_cnt;
  logic [7:0] key_lfsr;
  logic [4:0] step;
  logic [1:0] wait_cnt;
  logic [15:0] expect_val;
  logic usr_write;
  logic [15:0] usr_wdata;
  logic [33:0] op;
  logic [15:0] rdp_addr;
  logic [15:0] win_ofs_addr;
  logic [15:0] win_data_addr;

  assign rdp_addr = {ipc_pkg::IPC_RDP_TOP, rd_port, ipc_pkg::IPC_RDP_LOW}; // [RL4]
  assign win_ofs_addr = {base[15:5], ipc_pkg::IPC_WIN_OFS};
  assign win_data_addr = {base[15:5], ipc_pkg::IPC_WIN_DATA};

  // one bus cycle per step: {kind, address, data or expected value}
  always_comb begin
    op = {ipc_pkg::IPC_OP_WR, ipc_pkg::IPC_ADDR_PORT, 16'h0000};
    unique case (step)
      5'h00: op = {ipc_pkg::IPC_OP_WR, ipc_pkg::IPC_ADDR_PORT, 8'h00, ipc_pkg::IPC_IDX_WAKE};
      5'h01: op = {ipc_pkg::IPC_OP_WR, ipc_pkg::IPC_WDATA_PORT, 8'h00, ipc_pkg::IPC_WAKE_ALL}; // [RL9]
      5'h02: op = {ipc_pkg::IPC_OP_WR, ipc_pkg::IPC_ADDR_PORT, 8'h00, ipc_pkg::IPC_IDX_CSN};
      5'h03: op = {ipc_pkg::IPC_OP_WR, ipc_pkg::IPC_WDATA_PORT, 8'h00, ipc_pkg::IPC_CSN_VAL}; // [RL10]
      5'h04: op = {ipc_pkg::IPC_OP_WR, ipc_pkg::IPC_ADDR_PORT, 8'h00, ipc_pkg::IPC_IDX_BASE_HI};
      5'h05: op = {ipc_pkg::IPC_OP_WR, ipc_pkg::IPC_WDATA_PORT, 8'h00, base[15:8]}; // [RL12]
      5'h06: op = {ipc_pkg::IPC_OP_WR, ipc_pkg::IPC_ADDR_PORT, 8'h00, ipc_pkg::IPC_IDX_BASE_LO};
      5'h07: op = {ipc_pkg::IPC_OP_WR, ipc_pkg::IPC_WDATA_PORT, 8'h00, base[7:0]}; // [RL12]
      5'h08: op = {ipc_pkg::IPC_OP_WR, ipc_pkg::IPC_ADDR_PORT, 8'h00, ipc_pkg::IPC_IDX_RDPORT};
      5'h09: op = {ipc_pkg::IPC_OP_WR, ipc_pkg::IPC_WDATA_PORT, 8'h00, rd_port}; // [RL5]
      5'h0A: op = {ipc_pkg::IPC_OP_WR, ipc_pkg::IPC_ADDR_PORT, 8'h00, ipc_pkg::IPC_IDX_BASE_HI};
      5'h0B: op = {ipc_pkg::IPC_OP_RD, rdp_addr, 8'h00, base[15:8]};
      5'h0C: op = {ipc_pkg::IPC_OP_WR, ipc_pkg::IPC_ADDR_PORT, 8'h00, ipc_pkg::IPC_IDX_BASE_LO};
      5'h0D: op = {ipc_pkg::IPC_OP_RD, rdp_addr, 8'h00, base[7:0]};
      5'h0E: op = {ipc_pkg::IPC_OP_WR, ipc_pkg::IPC_ADDR_PORT, 8'h00, ipc_pkg::IPC_IDX_ACT};
      5'h0F: op = {ipc_pkg::IPC_OP_WR, ipc_pkg::IPC_WDATA_PORT, 8'h00, ipc_pkg::IPC_ACT_ON};
      5'h10: op = {ipc_pkg::IPC_OP_WR, win_ofs_addr, 8'h00, env_ofs}; // [RL20]
      5'h11: op = {ipc_pkg::IPC_OP_WR, win_data_addr, env_data}; // [RL20]
      default: op = {ipc_pkg::IPC_OP_WR, ipc_pkg::IPC_ADDR_PORT, 16'h0000};
    endcase
  end

  assign req_ready_out = (hstate == IPC_H_IDLE) && cfg_done_out && !start_in;
  assign cfg_busy_out = (hstate == IPC_H_KEY) || (hstate == IPC_H_STEP)
                        || (hstate == IPC_H_RD_WAIT);

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      hstate <= IPC_H_IDLE;
      base <= 16'h0000;
      rd_port <= 8'h00;
      env_ofs <= 8'h00;
      env_data <= 16'h0000;
      key_cnt <= 6'h00;
      key_lfsr <= ipc_pkg::IPC_KEY_SEED;
      step <= 5'h00;
      wait_cnt <= 2'h0;
      expect_val <= 16'h0000;
      usr_write <= 1'b0;
      usr_wdata <= 16'h0000;
      cfg_done_out <= 1'b0;
      cfg_ok_out <= 1'b0;
      resp_valid_out <= 1'b0;
      resp_data_out <= 16'h0000;
      bus.sa <= 16'h0000;
      bus.wdata <= 16'h0000;
      bus.iow <= 1'b0;
      bus.ior <= 1'b0;
    end else begin
      bus.iow <= 1'b0;
      bus.ior <= 1'b0;
      resp_valid_out <= 1'b0;
      unique case (hstate)
        IPC_H_IDLE: begin
          if (start_in) begin
            base <= base_addr_in;
            rd_port <= rd_port_in;
            env_ofs <= env_ofs_in;
            env_data <= env_data_in;
            key_cnt <= 6'h00;
            key_lfsr <= ipc_pkg::IPC_KEY_SEED;
            cfg_done_out <= 1'b0;
            cfg_ok_out <= 1'b1;
            hstate <= IPC_H_KEY;
          end else if (req_valid_in && req_ready_out) begin
            bus.iow <= 1'b1;
            bus.sa <= win_ofs_addr; // [RL18] [RL19]
            bus.wdata <= {8'h00, req_ofs_in};
            usr_write <= req_write_in;
            usr_wdata <= req_wdata_in;
            hstate <= IPC_H_USR_DATA;
          end
        end
        IPC_H_KEY: begin
          bus.iow <= 1'b1;
          bus.sa <= ipc_pkg::IPC_ADDR_PORT;
          bus.wdata <= {8'h00, (key_cnt < ipc_pkg::IPC_KEY_LEAD) ? ipc_pkg::IPC_KEY_ZERO
                                                                  : key_lfsr}; // [RL7]
          if (key_cnt >= ipc_pkg::IPC_KEY_LEAD) begin
            key_lfsr <= ipc_pkg::ipc_lfsr_next(key_lfsr);
          end
          key_cnt <= key_cnt + 6'h01;
          if (key_cnt == ipc_pkg::IPC_KEY_LEN - 6'h01) begin
            step <= 5'h00;
            hstate <= IPC_H_STEP;
          end
        end
        IPC_H_STEP: begin
          bus.sa <= op[31:16];
          bus.wdata <= op[15:0];
          if (op[33:32] == ipc_pkg::IPC_OP_RD) begin
            bus.ior <= 1'b1;
            expect_val <= op[15:0];
            wait_cnt <= 2'h0;
            hstate <= IPC_H_RD_WAIT;
          end else begin
            bus.iow <= 1'b1;
            step <= step + 5'h01;
            if (step == ipc_pkg::IPC_STEP_LAST) begin
              cfg_done_out <= 1'b1;
              hstate <= IPC_H_IDLE;
            end
          end
        end
        IPC_H_RD_WAIT: begin
          wait_cnt <= wait_cnt + 2'h1;
          if (bus.rvalid || (wait_cnt == ipc_pkg::IPC_RD_TIMEOUT)) begin
            // missing answer counts as a failed verify
            if (!bus.rvalid || (bus.rdata != expect_val)) begin
              cfg_ok_out <= 1'b0; // [RL13]
            end
            step <= step + 5'h01;
            hstate <= IPC_H_STEP;
          end
        end
        IPC_H_USR_DATA: begin
          bus.sa <= win_data_addr;
          bus.wdata <= usr_wdata;
          if (usr_write) begin
            bus.iow <= 1'b1; // [RL18]
            resp_valid_out <= 1'b1;
            resp_data_out <= usr_wdata;
            hstate <= IPC_H_IDLE;
          end else begin
            bus.ior <= 1'b1; // [RL19]
            wait_cnt <= 2'h0;
            hstate <= IPC_H_USR_WAIT;
          end
        end
        IPC_H_USR_WAIT: begin
          wait_cnt <= wait_cnt + 2'h1;
          if (bus.rvalid || (wait_cnt == ipc_pkg::IPC_RD_TIMEOUT)) begin
            resp_valid_out <= 1'b1;
            resp_data_out <= bus.rvalid ? bus.rdata : 16'h0000;
            hstate <= IPC_H_IDLE;
          end
        end
      endcase
    end
  end
endmodule

// *** verilog/ipc_isa_if.sv ***
// isa i/o cycle carrier between host and board
`timescale 1ns/1ps
interface ipc_isa_if;
  logic [15:0] sa;
  logic iow;
  logic ior;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic rvalid;
  modport dev (input sa, input iow, input ior, input wdata, output rdata, output rvalid);
  modport host (output sa, output iow, output ior, output wdata, input rdata, input rvalid);
endinterface

// *** verilog/ipc_pkg.sv ***
// shared constants for the plug and play config port and register window
package ipc_pkg;
  // fixed config ports
  localparam logic [15:0] IPC_ADDR_PORT = 16'h0279;
  localparam logic [15:0] IPC_WDATA_PORT = 16'h0A79;
  // relocatable read port: address = {rd_port, 2'b11}
  localparam logic [7:0] IPC_RDP_MIN = 8'h80;
  localparam logic [1:0] IPC_RDP_LOW = 2'h3;
  localparam logic [5:0] IPC_RDP_TOP = 6'h00;
  // initiation key
  localparam logic [5:0] IPC_KEY_LEN = 6'h22;
  localparam logic [5:0] IPC_KEY_LEAD = 6'h02;
  localparam logic [7:0] IPC_KEY_SEED = 8'h6A;
  localparam logic [7:0] IPC_KEY_ZERO = 8'h00;
  // config register indices
  localparam logic [7:0] IPC_IDX_RDPORT = 8'h00;
  localparam logic [7:0] IPC_IDX_CTRL = 8'h02;
  localparam logic [7:0] IPC_IDX_WAKE = 8'h03;
  localparam logic [7:0] IPC_IDX_CSN = 8'h06;
  localparam logic [7:0] IPC_IDX_ACT = 8'h30;
  localparam logic [7:0] IPC_IDX_BASE_HI = 8'h60;
  localparam logic [7:0] IPC_IDX_BASE_LO = 8'h61;
  localparam int IPC_CTRL_RESET_BIT = 0;
  localparam int IPC_CTRL_WAITKEY_BIT = 1;
  localparam int IPC_ACT_BIT = 0;
  localparam logic [7:0] IPC_WAKE_ALL = 8'h00;
  localparam logic [7:0] IPC_CSN_VAL = 8'h01;
  localparam logic [7:0] IPC_ACT_ON = 8'h01;
  // board window, offsets from the assigned base
  localparam int IPC_SPAN_BITS = 5;
  localparam logic [4:0] IPC_WIN_OFS = 5'h00;
  localparam logic [4:0] IPC_WIN_DATA = 5'h02;
  localparam logic [7:0] IPC_WIN_REGS = 8'hB4;
  // host sequencing
  localparam logic [1:0] IPC_RD_TIMEOUT = 2'h3;
  localparam logic [4:0] IPC_STEP_LAST = 5'h11;
  localparam logic [1:0] IPC_OP_WR = 2'h0;
  localparam logic [1:0] IPC_OP_RD = 2'h1;

  typedef enum logic [1:0] {
    IPC_WAIT4KEY,
    IPC_SLEEP,
    IPC_ISOLATE,
    IPC_CONFIG
  } ipc_cfg_state_t;

  function automatic logic [7:0] ipc_lfsr_next(input logic [7:0] v);
    ipc_lfsr_next = {v[0] ^ v[1], v[7:1]};
  endfunction
endpackage
